// [obc_top.sv]
// option register, reset-time mode selection and bootloader copy engine
//
// Notes on behaviour
// R1: sensitivity bit set means edge and level
// R2: every reset clears the sensitivity bit
// R3: watchdog disable bit set stops watchdog
// R4: every reset clears the watchdog disable bit
// R5: watchdog disable bit takes one write only
// R6: stop instruction always honoured on programmable part
// R7: normal irq level at release gives single chip
// R8: high irq voltage plus port c selects bootloader
// R9: single chip fetches vectors from programmable memory
// R10: full programming pass then separate verify pass
// R11: port c lines 0,1 drive the lamps
// R12: writing lamp off at verify; match lamp on success
// R13: mismatch puts failing address out, then halts
// R14: memory must start erased, all zero bytes
// R15: source reached through two address latches
// R16: external contents mirror the memory map exactly
// R17: bus clock is crystal clock over two
// R18: low supply drop input raises a request
// R19: low reset pin forces known start state
// R20: mask part fixes watchdog and stop options
// R21: option writes leave the supply drop bits alone
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
module obc_top #(
  parameter bit MASK_VARIANT      = 1'b0,
  parameter bit MASK_WDOG_ENABLE  = 1'b1,
  parameter bit MASK_STOP_ENABLE  = 1'b1,
  parameter int WRITING_LAMP_PULSE_CYCLES = obc_pkg::WRITING_LAMP_PULSE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        reset_pin_n,
  input  wire logic        irq_pin_n,
  input  wire logic        irq_high_voltage,
  input  wire logic        port_c_line_2,
  input  wire logic        port_c_line_3,
  input  wire logic        port_c_line_4,
  output logic             port_c_line_0_out,
  output logic             port_c_line_0_oe,
  output logic             port_c_line_1_out,
  output logic             port_c_line_1_oe,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [3:0]  supply_bits,
  input  wire logic        supply_drop_input_n,
  output logic             supply_drop_request,
  input  wire logic        irq_ack,
  output logic             irq_request,
  input  wire logic        stop_request,
  output logic             stop_enter,
  output logic             watchdog_enable,
  output logic             bus_clk,
  output logic             device_reset,
  output logic [12:0]      ext_addr,
  output logic             ext_addr_lo_load,
  output logic             ext_addr_hi_load,
  input  wire logic [7:0]  ext_data,
  output logic             boot_active,
  output logic             boot_halted,
  output logic             vector_from_writing_lamp_mem,
  input  wire logic [12:0] vector_addr,
  output logic      [7:0]  vector_data
);
  // ==========================================================================
  // functions
  function automatic logic [12:0] next_loc(input logic [12:0] a);
    if (a == obc_pkg::MAIN_LAST) begin
      next_loc = obc_pkg::VEC_FIRST;
    end else begin
      next_loc = a + 13'h0001;
    end
  endfunction

  function automatic obc_pkg::obc_mode_t decode_mode(input logic hv, input logic [2:0] s);
    if (!hv) begin
      decode_mode = obc_pkg::MODE_SINGLE;
    end else if (s == obc_pkg::SEL_VERIFY) begin
      decode_mode = obc_pkg::MODE_VERIFY;
    end else if (s == obc_pkg::SEL_WRITING_LAMP_ONE) begin
      decode_mode = obc_pkg::MODE_WRITING_LAMP_ONE;
    end else if (s == obc_pkg::SEL_WRITING_LAMP_FOUR) begin
      decode_mode = obc_pkg::MODE_WRITING_LAMP_FOUR;
    end else begin
      decode_mode = obc_pkg::MODE_INVALID;
    end
  endfunction

  localparam int PW = $clog2(WRITING_LAMP_PULSE_CYCLES + 1);

  // ==========================================================================
  // reset pin and bus clock
  logic pin_q_r;
  logic bus_tick_r;
  wire  core_rst   = !reset_pin_n;                            // see R19
  wire  pin_rise   = reset_pin_n && !pin_q_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_q_r    <= 1'b0;
      bus_tick_r <= 1'b0;
    end else begin
      pin_q_r    <= reset_pin_n;
      bus_tick_r <= !bus_tick_r;                              // see R17
    end
  end

  assign bus_clk      = bus_tick_r;
  assign device_reset = !pin_q_r;

  // ==========================================================================
  // mode latch at reset release
  obc_pkg::obc_mode_t mode_r;
  logic               start_r;
  wire  [2:0]         mode_sel  = {port_c_line_4, port_c_line_3, port_c_line_2};
  wire  obc_pkg::obc_mode_t mode_nxt = decode_mode(irq_high_voltage, mode_sel);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r  <= obc_pkg::MODE_SINGLE;
      start_r <= 1'b0;
    end else if (pin_rise) begin
      mode_r  <= mode_nxt;                                    // see R7 R8
      start_r <= (mode_nxt != obc_pkg::MODE_SINGLE) && (mode_nxt != obc_pkg::MODE_INVALID);
    end else begin
      start_r <= 1'b0;
    end
  end

  wire single_chip = (mode_r == obc_pkg::MODE_SINGLE);
  wire writing_lamp_pass   = (mode_r == obc_pkg::MODE_WRITING_LAMP_ONE) || (mode_r == obc_pkg::MODE_WRITING_LAMP_FOUR);

  // ==========================================================================
  // option register
  logic sens_r;
  logic wdog_dis_r;
  logic wdog_locked_r;
  wire  opt_hit = (reg_addr == obc_pkg::OPT_ADDR);
  wire  opt_wr  = reg_wr && opt_hit;
  // upper nibble reads from the supply drop logic and is never written here
  wire  [7:0] opt_view = {supply_bits, 2'b00, wdog_dis_r, sens_r};   // see R21

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sens_r        <= obc_pkg::OPT_SENS_RST;
      wdog_dis_r    <= obc_pkg::OPT_WDOG_RST;
      wdog_locked_r <= 1'b0;
      reg_rdata     <= obc_pkg::RDATA_RST;
    end else if (core_rst) begin
      sens_r        <= obc_pkg::OPT_SENS_RST;                 // see R2
      wdog_dis_r    <= obc_pkg::OPT_WDOG_RST;                 // see R4
      wdog_locked_r <= 1'b0;
      reg_rdata     <= obc_pkg::RDATA_RST;
    end else begin
      if (opt_wr) begin
        sens_r <= reg_wdata[obc_pkg::OPT_SENS_BIT];           // see R1
      end
      if (opt_wr && !wdog_locked_r) begin
        wdog_dis_r    <= reg_wdata[obc_pkg::OPT_WDOG_BIT];    // see R5
        wdog_locked_r <= 1'b1;
      end
      reg_rdata <= (reg_rd && opt_hit) ? opt_view : obc_pkg::RDATA_RST;
    end
  end

  // ==========================================================================
  // interrupt, stop, watchdog and supply drop outputs
  logic irq_q_r;
  logic irq_pend_r;
  wire  irq_fall     = !irq_pin_n && irq_q_r;
  // an edge in the ack cycle is kept, set beats clear
  wire  irq_pend_nxt = irq_fall || (irq_pend_r && !irq_ack);
  wire  stop_allowed = MASK_VARIANT ? MASK_STOP_ENABLE : 1'b1;       // see R6 R20
  wire  wdog_on      = MASK_VARIANT ? MASK_WDOG_ENABLE : !wdog_dis_r; // see R3 R20

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q_r              <= 1'b1;
      irq_pend_r           <= 1'b0;
      irq_request          <= 1'b0;
      stop_enter           <= 1'b0;
      watchdog_enable      <= 1'b1;
      supply_drop_request  <= 1'b0;
      vector_from_writing_lamp_mem <= 1'b0;
    end else if (core_rst) begin
      irq_q_r              <= 1'b1;
      irq_pend_r           <= 1'b0;
      irq_request          <= 1'b0;
      stop_enter           <= 1'b0;
      watchdog_enable      <= 1'b1;
      supply_drop_request  <= 1'b0;
      vector_from_writing_lamp_mem <= 1'b0;
    end else begin
      irq_q_r              <= irq_pin_n;
      irq_pend_r           <= irq_pend_nxt;
      irq_request          <= irq_pend_nxt || (sens_r && !irq_pin_n); // see R1
      stop_enter           <= stop_request && stop_allowed;           // see R6
      watchdog_enable      <= wdog_on;                                // see R3
      supply_drop_request  <= !supply_drop_input_n;                   // see R18
      vector_from_writing_lamp_mem <= single_chip && !MASK_VARIANT;           // see R9
    end
  end

  // ==========================================================================
  // bootloader engine, steps on bus clock ticks; the pulse wait counts every clk cycle
  obc_pkg::obc_boot_t st_r;
  logic [12:0]        loc_r;
  logic [7:0]         data_r;
  logic [1:0]         grp_r;
  logic [PW-1:0]      pulse_r;
  logic               verify_r;
  logic               write_lamp_r;
  logic               match_lamp_r;
  logic [7:0]         mem_rdata;

  wire step      = bus_tick_r;
  wire last_loc  = (loc_r == obc_pkg::VEC_LAST);
  // four-byte mode holds one long pulse per group of four locations
  wire grp_done  = (mode_r != obc_pkg::MODE_WRITING_LAMP_FOUR) || (grp_r == obc_pkg::GROUP_LAST)
                   || last_loc;
  wire mem_wr    = (st_r == obc_pkg::B_WRITE) && step;
  wire boot_busy = (st_r != obc_pkg::B_IDLE);
  wire [12:0] mem_addr = boot_busy ? loc_r : vector_addr;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r         <= obc_pkg::B_IDLE;
      loc_r        <= obc_pkg::MAIN_FIRST;
      data_r       <= 8'h00;
      grp_r        <= 2'h0;
      pulse_r      <= '0;
      verify_r     <= 1'b0;
      write_lamp_r <= 1'b0;
      match_lamp_r <= 1'b0;
    end else if (core_rst) begin
      st_r         <= obc_pkg::B_IDLE;
      loc_r        <= obc_pkg::MAIN_FIRST;
      grp_r        <= 2'h0;
      pulse_r      <= '0;
      verify_r     <= 1'b0;
      write_lamp_r <= 1'b0;
      match_lamp_r <= 1'b0;
    end else begin
      case (st_r)
        obc_pkg::B_IDLE: begin
          if (start_r) begin
            st_r         <= obc_pkg::B_LOAD_LO;
            loc_r        <= obc_pkg::MAIN_FIRST;
            verify_r     <= !writing_lamp_pass;                       // see R10
            write_lamp_r <= writing_lamp_pass;                        // see R12
          end
        end
        obc_pkg::B_LOAD_LO: begin
          if (step) begin
            st_r <= obc_pkg::B_LOAD_HI;                       // see R15
          end
        end
        obc_pkg::B_LOAD_HI: begin
          if (step) begin
            st_r <= obc_pkg::B_FETCH;
          end
        end
        obc_pkg::B_FETCH: begin
          if (step) begin
            data_r <= ext_data;
            st_r   <= verify_r ? obc_pkg::B_COMPARE : obc_pkg::B_WRITE;
          end
        end
        obc_pkg::B_WRITE: begin
          // relies on an erased, all-zero array before the pass
          if (step) begin
            st_r    <= grp_done ? obc_pkg::B_PULSE : obc_pkg::B_LOAD_LO; // see R14
            pulse_r <= '0;
            grp_r   <= grp_r + 2'h1;
            if (!grp_done) begin
              loc_r <= next_loc(loc_r);
            end
          end
        end
        obc_pkg::B_PULSE: begin
          if (pulse_r == PW'(WRITING_LAMP_PULSE_CYCLES - 1)) begin
            grp_r <= 2'h0;
            if (last_loc) begin
              st_r         <= obc_pkg::B_LOAD_LO;
              loc_r        <= obc_pkg::MAIN_FIRST;
              verify_r     <= 1'b1;                           // see R10
              write_lamp_r <= 1'b0;                           // see R12
            end else begin
              st_r  <= obc_pkg::B_LOAD_LO;
              loc_r <= next_loc(loc_r);                       // see R16
            end
          end else begin
            pulse_r <= pulse_r + PW'(1);
          end
        end
        obc_pkg::B_COMPARE: begin
          if (step) begin
            if (mem_rdata != data_r) begin
              st_r <= obc_pkg::B_HALT;                        // see R13
            end else if (last_loc) begin
              st_r         <= obc_pkg::B_DONE;
              match_lamp_r <= 1'b1;                           // see R12
            end else begin
              st_r  <= obc_pkg::B_LOAD_LO;
              loc_r <= next_loc(loc_r);
            end
          end
        end
        obc_pkg::B_DONE: begin
          st_r <= obc_pkg::B_DONE;
        end
        obc_pkg::B_HALT: begin
          st_r <= obc_pkg::B_HALT;
        end
        default: begin
          st_r <= obc_pkg::B_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // external address and lamps
  wire halted = (st_r == obc_pkg::B_HALT);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_addr         <= 13'h0000;
      ext_addr_lo_load <= 1'b0;
      ext_addr_hi_load <= 1'b0;
    end else begin
      ext_addr         <= boot_busy ? loc_r : 13'h0000;       // see R13
      // in halt both latches stay open so the failing address stands
      ext_addr_lo_load <= (st_r == obc_pkg::B_LOAD_LO) || halted; // see R15
      ext_addr_hi_load <= (st_r == obc_pkg::B_LOAD_HI) || halted;
    end
  end

  assign port_c_line_0_out = write_lamp_r;                    // see R11
  assign port_c_line_0_oe  = boot_busy;
  assign port_c_line_1_out = match_lamp_r;                    // see R11
  assign port_c_line_1_oe  = boot_busy;
  assign boot_active       = boot_busy;
  assign boot_halted       = halted;
  assign vector_data       = mem_rdata;

  // ==========================================================================
  // programmable memory
  obc_mem #(
    .AW (13),
    .DW (8)
  ) u_mem (
    .clk   (clk),
    .rst   (rst),
    .wr_en (mem_wr),
    .addr  (mem_addr),
    .wdata (data_r),
    .rdata (mem_rdata)
  );
endmodule

// [obc_pkg.sv]
// constants and types shared by the option and boot mode control block
package obc_pkg;
  // ==========================================================================
  // register map
  localparam logic [7:0]  OPT_ADDR      = 8'h0f;
  localparam int          OPT_SENS_BIT  = 0;
  localparam int          OPT_WDOG_BIT  = 1;
  localparam logic        OPT_SENS_RST  = 1'b0;
  localparam logic        OPT_WDOG_RST  = 1'b0;
  localparam logic [7:0]  RDATA_RST     = 8'h00;
  // ==========================================================================
  // mode select codes on port c lines 4,3,2
  localparam logic [2:0]  SEL_VERIFY    = 3'h5;
  localparam logic [2:0]  SEL_WRITING_LAMP_ONE  = 3'h6;
  localparam logic [2:0]  SEL_WRITING_LAMP_FOUR = 3'h7;
  // ==========================================================================
  // programmable memory map walked by the bootloader
  localparam logic [12:0] MAIN_FIRST    = 13'h0700;
  localparam logic [12:0] MAIN_LAST     = 13'h1eff;
  localparam logic [12:0] VEC_FIRST     = 13'h1ff0;
  localparam logic [12:0] VEC_LAST      = 13'h1fff;
  localparam logic [1:0]  GROUP_LAST    = 2'h3;
  // ==========================================================================
  // timing
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          WRITING_LAMP_PULSE_US = 1000;
  localparam int          WRITING_LAMP_PULSE_CYCLES =
    (WRITING_LAMP_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    MODE_SINGLE, MODE_VERIFY, MODE_WRITING_LAMP_ONE, MODE_WRITING_LAMP_FOUR, MODE_INVALID
  } obc_mode_t;
  typedef enum logic [3:0] {
    B_IDLE, B_LOAD_LO, B_LOAD_HI, B_FETCH, B_WRITE, B_PULSE, B_COMPARE,
    B_DONE, B_HALT
  } obc_boot_t;
endpackage

// [obc_mem.sv]
// on-chip programmable memory array with registered read data
`timescale 1ns/1ns
module obc_mem #(
  parameter int AW = 13,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  // ==========================================================================
  // storage
  logic [DW-1:0] mem_r [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_r[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= mem_r[addr];
    end
  end
endmodule

// [obc_top_assertions.sv]
// port-level checks for the option and boot mode block
`timescale 1ns/1ns
module obc_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        reset_pin_n,
  input wire logic        irq_pin_n,
  input wire logic        irq_high_voltage,
  input wire logic        port_c_line_2,
  input wire logic        port_c_line_3,
  input wire logic        port_c_line_4,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [3:0]  supply_bits,
  input wire logic        irq_request,
  input wire logic        stop_request,
  input wire logic        stop_enter,
  input wire logic        watchdog_enable,
  input wire logic        bus_clk,
  input wire logic [12:0] ext_addr,
  input wire logic        ext_addr_lo_load,
  input wire logic        ext_addr_hi_load,
  input wire logic        boot_active,
  input wire logic        boot_halted,
  input wire logic        vector_from_writing_lamp_mem
);
  logic opt_sel;
  logic wd_wr;
  assign opt_sel = reg_addr == obc_pkg::OPT_ADDR;
  assign wd_wr   = reg_wr && opt_sel && reg_wdata[obc_pkg::OPT_WDOG_BIT];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ========================================
  // sequences
  sequence s_release;
    !reset_pin_n ##1 reset_pin_n;
  endsequence
  sequence s_verify_sel;
    irq_high_voltage && {port_c_line_4, port_c_line_3, port_c_line_2} == obc_pkg::SEL_VERIFY;
  endsequence
  // ========================================
  // checks
  chk_bus_clk_half: assert property (
    $rose(bus_clk) |=> $fell(bus_clk) ##1 $rose(bus_clk))
    else $error("bus clock not half rate");
  chk_single_chip: assert property (
    s_release ##0 !irq_high_voltage |-> ##[1:3] (vector_from_writing_lamp_mem && !boot_active))
    else $error("single chip mode not entered");
  chk_boot_entry: assert property (
    s_release ##0 s_verify_sel |-> ##[1:4] boot_active)
    else $error("bootloader not started");
  chk_read_upper: assert property (
    reg_rd && opt_sel && reset_pin_n |=>
      reg_rdata[7:4] == $past(supply_bits) && reg_rdata[3:2] == 2'h0)
    else $error("option read upper bits wrong");
  chk_wdog_write: assert property (
    $fell(watchdog_enable) |-> $past(wd_wr) || $past(wd_wr, 2))
    else $error("watchdog stopped without a write");
  chk_wdog_reset: assert property (
    !reset_pin_n ##1 !reset_pin_n |=> watchdog_enable)
    else $error("watchdog not running after reset");
  chk_irq_edge: assert property (
    reset_pin_n && $fell(irq_pin_n) |=> irq_request)
    else $error("falling edge not latched");
  chk_stop_real: assert property (
    stop_request |=> stop_enter)
    else $error("stop request not honoured");
  chk_halt_hold: assert property (
    boot_halted && reset_pin_n ##1 reset_pin_n |->
      boot_halted && $stable(ext_addr) && ext_addr_lo_load && ext_addr_hi_load)
    else $error("failing address not held");
endmodule
bind obc_top obc_checker i_chk (.clk, .rst, .reset_pin_n, .irq_pin_n, .irq_high_voltage,
  .port_c_line_2, .port_c_line_3, .port_c_line_4, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .supply_bits, .irq_request, .stop_request, .stop_enter, .watchdog_enable,
  .bus_clk, .ext_addr, .ext_addr_lo_load, .ext_addr_hi_load, .boot_active, .boot_halted,
  .vector_from_writing_lamp_mem);

// [obc_ext_mem.sv]
// source memory model reached through two address latches
`timescale 1ns/1ns
module obc_ext_mem (
  input  wire logic        clk,
  input  wire logic [12:0] ext_addr,
  input  wire logic        ext_addr_lo_load,
  input  wire logic        ext_addr_hi_load,
  input  wire logic        fill_en,
  output logic      [7:0]  ext_data
);
  logic [12:0] latch_r;
  // ========================================
  // latches move only on the bootloader strobes
  always_ff @(posedge clk) begin
    if (ext_addr_lo_load) begin
      latch_r[7:0] <= ext_addr[7:0];
    end
    if (ext_addr_hi_load) begin
      latch_r[12:8] <= ext_addr[12:8];
    end
  end
  // image laid out on the on-chip map; fill off reads like a blank array
  assign ext_data = fill_en ? (latch_r[7:0] ^ 8'h5a) : 8'h00;
endmodule

// [tb.sv]
// self-checking bench for the option and boot mode block
`timescale 1ns/1ns
module tb;
  logic        clk, rst, reset_pin_n, irq_pin_n, irq_high_voltage, irq_ack, fill_en;
  logic        port_c_line_2, port_c_line_3, port_c_line_4, reg_wr, reg_rd;
  logic        stop_request, supply_drop_input_n, supply_drop_request, irq_request;
  logic        port_c_line_0_out, port_c_line_0_oe, port_c_line_1_out, port_c_line_1_oe;
  logic        stop_enter, watchdog_enable, bus_clk, device_reset, ext_addr_lo_load;
  logic        ext_addr_hi_load, boot_active, boot_halted, vector_from_writing_lamp_mem;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, ext_data, vector_data, d;
  logic [3:0]  supply_bits;
  logic [12:0] vector_addr, ext_addr;
  logic        sens_m, wd_m, locked_m;
  int          num_errors, cmp_count, cyc, n;
  integer      seed = 32'h6738_8e94;
  obc_top #(.WRITING_LAMP_PULSE_CYCLES(3)) i_dut (.clk, .rst, .reset_pin_n, .irq_pin_n,
    .irq_high_voltage, .port_c_line_2, .port_c_line_3, .port_c_line_4, .port_c_line_0_out,
    .port_c_line_0_oe, .port_c_line_1_out, .port_c_line_1_oe, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .supply_bits, .supply_drop_input_n, .supply_drop_request, .irq_ack,
    .irq_request, .stop_request, .stop_enter, .watchdog_enable, .bus_clk, .device_reset,
    .ext_addr, .ext_addr_lo_load, .ext_addr_hi_load, .ext_data, .boot_active, .boot_halted,
    .vector_from_writing_lamp_mem, .vector_addr, .vector_data);
  obc_ext_mem i_src (.clk, .ext_addr, .ext_addr_lo_load, .ext_addr_hi_load, .fill_en,
    .ext_data);
  always #5 clk = ~clk;
  // full verify pass (about 49k cycles) is the long pole; ceiling sits about 10k cycles above it
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      finish_test();
    end
  end
  // ========================================
  // helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == obc_pkg::OPT_ADDR) begin
      sens_m   = v[0];
      wd_m     = locked_m ? wd_m : v[1];
      locked_m = 1'b1;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic pin_reset(input logic hv, input logic [2:0] sel);
    @(posedge clk);
    reset_pin_n      <= 1'b0;
    irq_high_voltage <= hv;
    {port_c_line_4, port_c_line_3, port_c_line_2} <= sel;
    repeat (3) @(posedge clk);
    reset_pin_n <= 1'b1;
    {sens_m, wd_m, locked_m} = 3'h0;
    step(4);
  endtask
  task automatic ack;
    @(posedge clk);
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
    step(2);
  endtask
  task automatic finish_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ========================================
  // main sequence
  initial begin
    clk = 1'b0;
    {num_errors, cmp_count} = '0;
    // the array comes up erased, all zero bytes, before any pass
    for (int i = 0; i < 8192; i++) begin
      i_dut.u_mem.mem_r[i] = 8'h00;
    end
    {rst, reset_pin_n, irq_pin_n, supply_drop_input_n} = 4'hb;
    {irq_high_voltage, irq_ack, reg_wr, reg_rd, stop_request, fill_en} = '0;
    {port_c_line_4, port_c_line_3, port_c_line_2, reg_addr, reg_wdata} = '0;
    {supply_bits, vector_addr} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    pin_reset(1'b0, 3'h7);
    chk({vector_from_writing_lamp_mem, boot_active, device_reset}, 3'h4);
    chk(watchdog_enable, 1'b1);
    d[0] = bus_clk;
    step(1);
    chk(bus_clk, !d[0]);
    rd(obc_pkg::OPT_ADDR, {supply_bits, 4'h0});
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      d[1] = d[1] | (i == 0);
      supply_bits <= $random(seed);
      vector_addr <= $random(seed);
      wr(obc_pkg::OPT_ADDR, d);
      rd(obc_pkg::OPT_ADDR, {supply_bits, 2'h0, wd_m, sens_m});
      chk(watchdog_enable, !wd_m);
      d = $random(seed);
      rd((d == obc_pkg::OPT_ADDR) ? 8'h10 : d, 8'h00);
    end
    pin_reset(1'b0, 3'h0);
    rd(obc_pkg::OPT_ADDR, {supply_bits, 4'h0});
    wr(obc_pkg::OPT_ADDR, 8'h00);
    wr(obc_pkg::OPT_ADDR, 8'h02);
    chk(watchdog_enable, 1'b1);
    for (int s = 0; s < 2; s++) begin
      wr(obc_pkg::OPT_ADDR, {7'h00, s[0]});
      irq_pin_n <= 1'b0;
      step(2);
      chk(irq_request, 1'b1);
      ack();
      chk(irq_request, s[0]);
      irq_pin_n <= 1'b1;
      ack();
      chk(irq_request, 1'b0);
    end
    {stop_request, supply_drop_input_n} <= 2'h2;
    step(2);
    chk({stop_enter, supply_drop_request}, 2'h3);
    {stop_request, supply_drop_input_n} <= 2'h1;
    step(2);
    chk({stop_enter, supply_drop_request}, 2'h0);
    pin_reset(1'b1, 3'h4);
    step(8);
    chk({boot_active, port_c_line_0_oe, port_c_line_1_oe}, 3'h0);
    // array still blank from power-up, so the verify pass mismatches at the first location
    fill_en <= 1'b1;
    pin_reset(1'b1, obc_pkg::SEL_VERIFY);
    for (n = 0; n < 2000 && boot_halted !== 1'b1; n++) @(posedge clk);
    step(1);
    chk({boot_halted, ext_addr}, {3'h1, obc_pkg::MAIN_FIRST});
    chk({port_c_line_0_out, port_c_line_1_out}, 2'h0);
    fill_en <= 1'b0;
    pin_reset(1'b1, obc_pkg::SEL_VERIFY);
    for (n = 0; n < 55000 && port_c_line_1_out !== 1'b1 && boot_halted !== 1'b1; n++)
      @(posedge clk);
    step(1);
    chk({port_c_line_1_out, port_c_line_0_out, boot_halted}, 3'h4);
    fill_en <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      pin_reset(1'b1, m ? obc_pkg::SEL_WRITING_LAMP_FOUR : obc_pkg::SEL_WRITING_LAMP_ONE);
      step(40);
      chk({port_c_line_0_out, port_c_line_0_oe, port_c_line_1_out}, 3'h6);
    end
    vector_addr <= obc_pkg::MAIN_FIRST;
    pin_reset(1'b0, 3'h5);
    chk({vector_from_writing_lamp_mem, boot_active}, 2'h2);
    // first location holds the source image byte, low address 00 xor 5a
    chk(vector_data, 8'h5a);
    finish_test();
  end
endmodule
